// ---- ncsc_pkg.sv ----
// constants for the oscillator channel select control block
// assumes an 8-bit register port on the internal converter clock
package ncsc_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CHAN_W = 4;
	localparam int unsigned MODE_W = 4;
	localparam logic [ADDR_W-1:0] OSC_CHAN_CTRL_ADDR = 16'h0354;
	localparam logic [DATA_W-1:0] OSC_CHAN_CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	localparam int unsigned MODE_LSB = 4;
	localparam int unsigned MAP_LSB = 0;
	localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
	localparam logic [CHAN_W-1:0] CHAN_ONE = 4'h1;
	localparam logic [1:0] UPPER_ZERO = 2'h0;
	localparam logic [MODE_W-1:0] MODE_REGISTER = 4'h0;
	localparam logic [MODE_W-1:0] MODE_B0_A0 = 4'h1;
	localparam logic [MODE_W-1:0] MODE_B1_A1 = 4'h2;
	localparam logic [MODE_W-1:0] MODE_A1_A0 = 4'h3;
	localparam logic [MODE_W-1:0] MODE_B1_B0 = 4'h4;
	localparam logic [MODE_W-1:0] MODE_INTERLEAVE = 4'h5;
	localparam logic [MODE_W-1:0] MODE_GROUPED = 4'h6;
	localparam logic [MODE_W-1:0] MODE_EDGE_A0 = 4'h8;
	localparam logic [MODE_W-1:0] MODE_EDGE_A1 = 4'h9;
	localparam logic [MODE_W-1:0] MODE_EDGE_B0 = 4'hA;
	localparam logic [MODE_W-1:0] MODE_EDGE_B1 = 4'hB;
	localparam logic [1:0] PIN_A0 = 2'h0;
	localparam logic [1:0] PIN_A1 = 2'h1;
	localparam logic [1:0] PIN_B0 = 2'h2;
	localparam logic [1:0] PIN_B1 = 2'h3;
endpackage

// ---- ncsc_edge_counter.sv ----
// edge-stepped channel counter with programmable wrap value
// assumes pins are already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ncsc_edge_counter (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] pins,
	input wire logic [1:0] pin_sel,
	input wire logic count_en,
	input wire logic [ncsc_pkg::CHAN_W-1:0] wrap_value,
	output logic [ncsc_pkg::CHAN_W-1:0] count
);
	logic [3:0] pins_prev_reg;
	logic [ncsc_pkg::CHAN_W-1:0] count_reg;
	logic rise;

	// history kept in every mode so entering an edge mode sees no false edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pins_prev_reg <= 4'h0;
		end else begin
			pins_prev_reg <= pins;
		end
	end

	assign rise = pins[pin_sel] & ~pins_prev_reg[pin_sel];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= ncsc_pkg::CHAN_RESET;
		end else if (count_en && rise) begin
			if (count_reg >= wrap_value) begin
				count_reg <= ncsc_pkg::CHAN_RESET;
			end else begin
				count_reg <= count_reg + ncsc_pkg::CHAN_ONE;
			end
		end
	end

	assign count = count_reg;
endmodule // ncsc_edge_counter
`default_nettype wire

// ---- ncsc_top.sv ----
// channel source selection for the third downconverter path oscillator
// assumes an 8-bit register port and select pins synchronous to sys_clk
// outputs are registered; a pin change shows one cycle later, two in edge modes
`timescale 1ns/1ps
`default_nettype none
module ncsc_top (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ncsc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ncsc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ncsc_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rdata_valid,
	input wire logic [ncsc_pkg::CHAN_W-1:0] path_channel_field,
	input wire logic select_a0,
	input wire logic select_a1,
	input wire logic select_b0,
	input wire logic select_b1,
	output logic [ncsc_pkg::CHAN_W-1:0] active_channel,
	output logic [ncsc_pkg::CHAN_W-1:0] map_channel
);
	logic [ncsc_pkg::DATA_W-1:0] ctrl_reg;
	logic [ncsc_pkg::CHAN_W-1:0] active_reg;
	logic [ncsc_pkg::CHAN_W-1:0] active_next;
	logic [ncsc_pkg::CHAN_W-1:0] map_reg;
	logic [ncsc_pkg::DATA_W-1:0] rdata_reg;
	logic rvalid_reg;
	logic [ncsc_pkg::MODE_W-1:0] mode;
	logic [ncsc_pkg::CHAN_W-1:0] wrap_value;
	logic [ncsc_pkg::CHAN_W-1:0] edge_count;
	logic [3:0] pins;
	logic [1:0] pin_sel;
	logic edge_mode;
	logic hit;
	logic ctrl_wr;
	logic reserved_mode;
	logic [ncsc_pkg::DATA_W-1:0] rdata_next;
	logic [ncsc_pkg::CHAN_W-1:0] pin_channel;

	// upper nibble picks the source, lower nibble is map channel and wrap
	assign mode = ctrl_reg[ncsc_pkg::MODE_LSB +: ncsc_pkg::MODE_W];
	assign wrap_value = ctrl_reg[ncsc_pkg::MAP_LSB +: ncsc_pkg::CHAN_W];
	assign hit = (reg_addr == ncsc_pkg::OSC_CHAN_CTRL_ADDR);
	assign ctrl_wr = reg_wr && hit;
	assign pins = {select_b1, select_b0, select_a1, select_a0};

	// control register write
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= ncsc_pkg::OSC_CHAN_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= reg_wdata;
		end
	end

	// read data mux; unmapped addresses answer zero
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd && hit) begin
			rdata_next = ctrl_reg;
		end else if (reg_rd) begin
			rdata_next = ncsc_pkg::UNMAPPED_READ;
		end
	end

	// data holds between reads so a slow reader still finds it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= ncsc_pkg::UNMAPPED_READ;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// valid is a one-cycle pulse per read strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd;
		end
	end

	// edge mode decode and pin choice
	always_comb begin
		edge_mode = 1'b1;
		pin_sel = ncsc_pkg::PIN_A0;
		case (mode)
			ncsc_pkg::MODE_EDGE_A0: begin
				pin_sel = ncsc_pkg::PIN_A0;
			end
			ncsc_pkg::MODE_EDGE_A1: begin
				pin_sel = ncsc_pkg::PIN_A1;
			end
			ncsc_pkg::MODE_EDGE_B0: begin
				pin_sel = ncsc_pkg::PIN_B0;
			end
			ncsc_pkg::MODE_EDGE_B1: begin
				pin_sel = ncsc_pkg::PIN_B1;
			end
			default: begin
				edge_mode = 1'b0;
			end
		endcase
	end

	// relies on one rising edge per wanted step
	// counter advances only in edge modes
	ncsc_edge_counter u_counter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pins(pins),
		.pin_sel(pin_sel),
		.count_en(edge_mode),
		.wrap_value(wrap_value),
		.count(edge_count)
	);

	// channel formed straight from the pins, modes 1 to 6
	always_comb begin
		pin_channel = ncsc_pkg::CHAN_RESET;
		case (mode)
			ncsc_pkg::MODE_B0_A0: begin
				pin_channel = {ncsc_pkg::UPPER_ZERO, select_b0, select_a0};
			end
			ncsc_pkg::MODE_B1_A1: begin
				pin_channel = {ncsc_pkg::UPPER_ZERO, select_b1, select_a1};
			end
			ncsc_pkg::MODE_A1_A0: begin
				pin_channel = {ncsc_pkg::UPPER_ZERO, select_a1, select_a0};
			end
			ncsc_pkg::MODE_B1_B0: begin
				pin_channel = {ncsc_pkg::UPPER_ZERO, select_b1, select_b0};
			end
			ncsc_pkg::MODE_INTERLEAVE: begin
				pin_channel = {select_b1, select_a1, select_b0, select_a0};
			end
			ncsc_pkg::MODE_GROUPED: begin
				pin_channel = {select_b1, select_b0, select_a1, select_a0};
			end
			default: begin
				pin_channel = ncsc_pkg::CHAN_RESET;
			end
		endcase
	end

	// source selection per mode
	always_comb begin
		active_next = active_reg;
		case (mode)
			ncsc_pkg::MODE_REGISTER: begin
				active_next = path_channel_field;
			end
			ncsc_pkg::MODE_B0_A0, ncsc_pkg::MODE_B1_A1, ncsc_pkg::MODE_A1_A0,
			ncsc_pkg::MODE_B1_B0, ncsc_pkg::MODE_INTERLEAVE, ncsc_pkg::MODE_GROUPED: begin
				active_next = pin_channel;
			end
			ncsc_pkg::MODE_EDGE_A0, ncsc_pkg::MODE_EDGE_A1,
			ncsc_pkg::MODE_EDGE_B0, ncsc_pkg::MODE_EDGE_B1: begin
				active_next = edge_count;
			end
			default: begin
				active_next = active_reg;
			end
		endcase
	end

	// any code outside the defined set is reserved
	always_comb begin
		reserved_mode = 1'b0;
		case (mode)
			ncsc_pkg::MODE_REGISTER, ncsc_pkg::MODE_B0_A0, ncsc_pkg::MODE_B1_A1,
			ncsc_pkg::MODE_A1_A0, ncsc_pkg::MODE_B1_B0, ncsc_pkg::MODE_INTERLEAVE,
			ncsc_pkg::MODE_GROUPED, ncsc_pkg::MODE_EDGE_A0, ncsc_pkg::MODE_EDGE_A1,
			ncsc_pkg::MODE_EDGE_B0, ncsc_pkg::MODE_EDGE_B1: begin
				reserved_mode = 1'b0;
			end
			default: begin
				reserved_mode = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			active_reg <= ncsc_pkg::CHAN_RESET;
		end else if (!reserved_mode) begin
			active_reg <= active_next;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			map_reg <= ncsc_pkg::CHAN_RESET;
		end else begin
			map_reg <= wrap_value;
		end
	end

	// every output straight from a flip-flop
	assign active_channel = active_reg;
	assign map_channel = map_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rdata_valid = rvalid_reg;
endmodule // ncsc_top
`default_nettype wire

// ---- ncsc_chk.sv ----
// assertions for ncsc_top
// assumes binding onto ncsc_top
`timescale 1ns/1ps
`default_nettype none
module ncsc_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [3:0] path_channel_field,
	input wire logic select_a0,
	input wire logic select_a1,
	input wire logic select_b0,
	input wire logic select_b1,
	input wire logic [3:0] active_channel,
	input wire logic [3:0] map_channel
);
	logic [7:0] c;
	logic [3:0] cnt, p, pp, e, m;
	logic s_rise;
	assign m = c[7:4];
	assign p = {select_b1, select_b0, select_a1, select_a0};
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst) c <= 8'h00;
		else if (reg_wr && reg_addr == 16'h0354) c <= reg_wdata;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst) pp <= 4'h0;
		else pp <= p;
	// wrap check is >= so a lowered limit still wraps
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst) cnt <= 4'h0;
		else if (s_rise) cnt <= (cnt >= c[3:0]) ? 4'h0 : cnt + 4'h1;
	assign s_rise = m[3:2] == 2'h2 && p[m[1:0]] && !pp[m[1:0]];
	always_comb
		case (m)
			4'h1: e = {2'h0, select_b0, select_a0};
			4'h2: e = {2'h0, select_b1, select_a1};
			4'h3: e = {2'h0, select_a1, select_a0};
			4'h4: e = {2'h0, select_b1, select_b0};
			4'h5: e = {select_b1, select_a1, select_b0, select_a0};
			default: e = p;
		endcase
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_step;
		s_rise ##1 m[3:2] == 2'h2;
	endsequence
	chk_reg_source: assert property (m == 4'h0 |=> active_channel == $past(path_channel_field))
		else $error("mode 0 channel");
	chk_pair_pins: assert property (m inside {4'h1, 4'h2} |=> active_channel == $past(e))
		else $error("pin pair channel");
	chk_bank_pins: assert property (m inside {4'h3, 4'h4} |=> active_channel == $past(e))
		else $error("pin bank channel");
	chk_four_pins: assert property (m inside {4'h5, 4'h6} |=> active_channel == $past(e))
		else $error("four pin channel");
	chk_edge_step: assert property (s_step |=> active_channel == $past(cnt))
		else $error("edge step");
	chk_wrap_zero: assert property (s_rise && cnt >= c[3:0] ##1 m[3:2] == 2'h2 |=> active_channel == 4'h0)
		else $error("wrap");
	chk_map_follow: assert property (map_channel == $past(c[3:0]))
		else $error("map channel");
	chk_reserved_hold: assert property (m == 4'h7 || m >= 4'hC |=> $stable(active_channel))
		else $error("reserved hold");
endmodule // ncsc_chk
bind ncsc_top ncsc_chk chk_i (.*);
`default_nettype wire

// ---- ncsc_pin_drv.sv ----
// far-side controller driving the select pins
// assumes requests change at falling edges
`timescale 1ns/1ps
`default_nettype none
module ncsc_pin_drv (
	input wire logic [3:0] lvl,
	input wire logic [3:0] kick,
	output logic [3:0] pins
);
	assign pins = lvl | kick;
endmodule // ncsc_pin_drv
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for ncsc_top
// assumes ncsc_chk binds itself
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk, nrst, reg_wr, reg_rd, reg_rdata_valid;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] path_channel_field, lvl, kick, active_channel, map_channel, cnt;
	wire select_a0, select_a1, select_b0, select_b1;
	int mismatches, n_compared, cyc, k;
	// mode, pins b1 b0 a1 a0, path field, expected channel
	logic [15:0] rows [7] = '{16'h0099, 16'h1602, 16'h2601, 16'h3A02, 16'h4501, 16'h5305, 16'h6909};
	ncsc_pin_drv pd (.lvl(lvl), .kick(kick), .pins({select_b1, select_b0, select_a1, select_a0}));
	ncsc_top dut (.*);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk) reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk) reg_rd = 1'b0;
		chk({7'h00, reg_rdata_valid}, 8'h01);
		chk(reg_rdata, exp);
	endtask
	// kick stays low for three cycles after each high
	task automatic step(input int s);
		kick = 4'h1 << s;
		@(negedge sys_clk) kick = 4'h0;
		cnt = (cnt >= 4'h2) ? 4'h0 : cnt + 4'h1;
		repeat (3) @(negedge sys_clk);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 3000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata, path_channel_field, lvl, kick, cnt} = '0;
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		rd(16'h0354, 8'h00);
		foreach (rows[i]) begin
			wr(16'h0354, {rows[i][15:12], 4'h0});
			lvl = rows[i][11:8];
			path_channel_field = rows[i][7:4];
			repeat (3) @(negedge sys_clk);
			chk({4'h0, active_channel}, {4'h0, rows[i][3:0]});
		end
		lvl = 4'h0;
		for (k = 0; k < 4; k++) begin
			wr(16'h0354, {2'h2, k[1:0], 4'h2});
			repeat (4) begin
				step(k);
				chk({4'h0, active_channel}, {4'h0, cnt});
			end
		end
		wr(16'h0354, 8'h72);
		lvl = 4'hF;
		repeat (3) @(negedge sys_clk);
		chk({4'h0, active_channel}, {4'h0, cnt});
		wr(16'h0354, 8'hCF);
		lvl = 4'h0;
		@(negedge sys_clk);
		wr(16'h0355, 8'h10);
		repeat (3) @(negedge sys_clk);
		chk({4'h0, active_channel}, {4'h0, cnt});
		chk({4'h0, map_channel}, 8'h0F);
		rd(16'h0355, 8'h00);
		@(negedge sys_clk);
		rd(16'h0354, 8'hCF);
		// mid-run reset clears outputs; mode 0 then follows the path field
		path_channel_field = 4'h6;
		nrst = 1'b0;
		@(negedge sys_clk);
		chk({4'h0, active_channel}, 8'h00);
		chk({4'h0, map_channel}, 8'h00);
		chk(reg_rdata, 8'h00);
		chk({7'h00, reg_rdata_valid}, 8'h00);
		nrst = 1'b1;
		@(negedge sys_clk);
		chk({4'h0, active_channel}, 8'h06);
		rd(16'h0354, 8'h00);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
